/* logic/tcs_pkg.sv */
package tcs_pkg;

    // Converter and sequence shape
    localparam int ADC_W    = 10;
    localparam int N_GRP    = 6;
    localparam int N_DIG    = 4;
    localparam int N_CH     = 9;
    localparam int CH_W     = 4;
    localparam int ADC_DIV  = 4;

    localparam logic [ADC_W-1:0] ADC_MSB_MASK = 10'h200;
    localparam logic [1:0]       DIV_LAST     = 2'(ADC_DIV - 1);

    // Channel order of the sequencer
    localparam logic [CH_W-1:0] CH_REGULATED_SUPPLY_SENSE = 4'h0;
    localparam logic [CH_W-1:0] CH_VS    = 4'h1;
    localparam logic [CH_W-1:0] CH_WAKE  = 4'h2;
    localparam logic [CH_W-1:0] CH_GRP0  = 4'h3;
    localparam logic [CH_W-1:0] CH_LAST  = 4'h8;

    // Thermal filter time and its cycle count
    localparam int CLK_KHZ  = 10000;
    localparam int FILT_US  = 100;
    localparam int FILT_CNT = (FILT_US * CLK_KHZ + 999) / 1000;
    localparam int FILT_W   = $clog2(FILT_CNT + 1);

    localparam logic [FILT_W-1:0] FILT_FULL = FILT_W'(FILT_CNT);
    localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CNT - 1);

    // Register byte offsets
    localparam logic [7:0] OFF_CONFIG   = 8'h00;
    localparam logic [7:0] OFF_WARN_THR = 8'h04;
    localparam logic [7:0] OFF_SD_THR   = 8'h08;
    localparam logic [7:0] OFF_STATUS   = 8'h0c;
    localparam logic [7:0] OFF_REGULATED_SUPPLY_SENSE    = 8'h10;
    localparam logic [7:0] OFF_VS       = 8'h14;
    localparam logic [7:0] OFF_WAKE     = 8'h18;
    localparam logic [7:0] OFF_TEMP12   = 8'h1c;
    localparam logic [7:0] OFF_TEMP34   = 8'h20;
    localparam logic [7:0] OFF_TEMP56   = 8'h24;
    localparam logic [7:0] ADDR_WORD    = 8'hfc;

    // Field positions
    localparam int CFG_CLUSTER_BIT = 0;
    localparam int CFG_ADC_EN_BIT  = 1;
    localparam int STS_WARN_LSB    = 0;
    localparam int STS_SD_LSB      = 8;
    localparam int STS_TW_BIT      = 16;
    localparam int STS_FIRST_SHUTDOWN_FLAG_BIT    = 17;
    localparam int STS_SECOND_SHUTDOWN_LEVEL_BIT    = 18;
    localparam int TEMP_HI_LSB     = 16;

    // Reset values
    localparam logic             CLUSTER_RST  = 1'b0;
    localparam logic             ADC_EN_RST   = 1'b1;
    localparam logic [ADC_W-1:0] WARN_THR_RST = 10'h1c2;
    localparam logic [ADC_W-1:0] SD_THR_RST   = 10'h199;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Converter states
    typedef enum logic [1:0] {
        SAR_IDLE   = 2'b00,
        SAR_SAMPLE = 2'b01,
        SAR_CONV   = 2'b11
    } tcs_sar_state_t;

endpackage : tcs_pkg

/* logic/tcs_sar.sv */
`timescale 1ns/1ps
module tcs_sar import tcs_pkg::*; (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Control
    input  wire logic             step_en,
    input  wire logic             start,
    input  wire logic             cmp_hi,
    // Analog side
    output logic                  sample,
    output logic [ADC_W-1:0]      dac_code,
    // Result
    output logic                  done,
    output logic [ADC_W-1:0]      result
);

    tcs_sar_state_t   state_r, state_nxt;
    logic [ADC_W-1:0] dac_r, dac_nxt;
    logic [ADC_W-1:0] bit_r, bit_nxt;
    logic [ADC_W-1:0] res_r, res_nxt;
    logic             done_r, done_nxt;

    // State and trial registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= SAR_IDLE;
            dac_r   <= '0;
            bit_r   <= '0;
            res_r   <= '0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dac_r   <= dac_nxt;
            bit_r   <= bit_nxt;
            res_r   <= res_nxt;
            done_r  <= done_nxt;
        end
    end

    // One trial bit per converter clock, MSB first
    always_comb begin
        logic [ADC_W-1:0] kept;
        kept      = cmp_hi ? dac_r : (dac_r & ~bit_r);
        state_nxt = state_r;
        dac_nxt   = dac_r;
        bit_nxt   = bit_r;
        res_nxt   = res_r;
        done_nxt  = 1'b0;
        unique case (state_r)
            SAR_IDLE: begin
                if (start) begin
                    state_nxt = SAR_SAMPLE;
                end
            end
            SAR_SAMPLE: begin
                if (step_en) begin
                    state_nxt = SAR_CONV;
                    bit_nxt   = ADC_MSB_MASK;
                    dac_nxt   = ADC_MSB_MASK;
                end
            end
            SAR_CONV: begin
                if (step_en) begin
                    if (bit_r[0]) begin
                        res_nxt   = kept;
                        dac_nxt   = kept;
                        done_nxt  = 1'b1;
                        state_nxt = SAR_IDLE;
                    end else begin
                        bit_nxt = bit_r >> 1;
                        dac_nxt = kept | (bit_r >> 1);
                    end
                end
            end
            default: state_nxt = SAR_IDLE;
        endcase
    end

    assign sample   = (state_r == SAR_SAMPLE);
    assign dac_code = dac_r;
    assign done     = done_r;
    assign result   = res_r;

endmodule : tcs_sar

/* logic/tcs_thermal.sv */
// Operation
// (R1) Warning flag sets only after over-warning persists a full filter time.
// (R2) Shutdown over threshold for filter time sets flag, turns all stages off.
// (R3) On shutdown the external gate drives go resistive-low, not active-low.
// (R4) Software clears flags; cleared flags re-enable the disabled stages.
// (R5) Shutdown counting needs warning set first, so two filter times minimum.
// (R6) Six thermal groups, each with its own sensor and shutdown decision.
// (R7) Per-group warning and shutdown flags in one register; codes in three.
// (R8) Code equals (350 - temperature) / 0.488; hotter means smaller.
// (R9) Standard: any group shutdown turns all off; regulator waits for level two.
// (R10) Cluster setting: only the shutting group's outputs go off.
// (R11) Global or regulator group shutdown turns all off except main regulator.
// (R12) Groups one to four judged from ADC codes, five and six by comparators.
// (R13) 10-bit SAR converter stepping at main clock divided by four.
// (R14) Nine channels converted in turn, each refreshed every nine conversions.
// (R15) Host clears flags by writing ones to the bits to clear.
// (R16) Fixed order: regulated supply, supply, wake, groups one to six.
// (R17) A code at or below the threshold code counts as over threshold.
`timescale 1ns/1ps
module tcs_thermal import tcs_pkg::*; (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // AXI4-Lite write
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Converter front end
    input  wire logic              adc_cmp_hi,
    output logic [CH_W-1:0]        adc_chan_sel,
    output logic                   adc_sample,
    output logic [ADC_W-1:0]       adc_dac_code,
    // Group five and six comparators, and level two
    input  wire logic [1:0]        ana_warn_cmp,
    input  wire logic [1:0]        ana_sd_cmp,
    input  wire logic              ana_second_cmp,
    // Output stage control
    output logic [N_GRP-1:0]       group_off,
    output logic                   gate_resistive_low,
    output logic                   main_regulator_off
);

    // Two-stage synchroniser for all asynchronous inputs
    logic [5:0] meta_r, sync_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {ana_second_cmp, ana_sd_cmp, ana_warn_cmp, adc_cmp_hi};
            sync_r <= meta_r;
        end
    end
    wire       cmp_hi_s = sync_r[0];
    wire [1:0] warn_s   = sync_r[2:1];
    wire [1:0] sd_s     = sync_r[4:3];
    wire       second_s = sync_r[5];

    // Registers and flags
    logic              cluster_r, adc_en_r;
    logic [ADC_W-1:0]  warn_thr_r, sd_thr_r;
    logic [N_GRP-1:0]  warn_r, sd_r;
    logic              second_r;
    logic [ADC_W-1:0]  res_r [N_CH];

    // Converter rate divider
    logic [1:0] div_r;
    wire        step_en = (div_r == DIV_LAST); // (R13)
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_r <= '0;
        end else begin
            div_r <= step_en ? 2'h0 : div_r + 2'h1;
        end
    end

    // Converter instance
    logic             sar_done;
    logic [ADC_W-1:0] sar_result;
    tcs_sar u_sar (
        .clk      (clk),
        .resetn   (resetn),
        .step_en  (step_en),
        .start    (adc_en_r),
        .cmp_hi   (cmp_hi_s),
        .sample   (adc_sample),
        .dac_code (adc_dac_code),
        .done     (sar_done),
        .result   (sar_result)
    );

    // Channel sequencer and result store
    logic [CH_W-1:0] chan_r;
    wire             chan_wrap = (chan_r == CH_LAST);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan_r <= CH_REGULATED_SUPPLY_SENSE;
            for (int i = 0; i < N_CH; i++) begin
                res_r[i] <= '0;
            end
        end else if (sar_done) begin
            res_r[chan_r] <= sar_result;                              // (R16)
            chan_r        <= chan_wrap ? CH_REGULATED_SUPPLY_SENSE : chan_r + 4'h1;    // (R14)
        end
    end
    assign adc_chan_sel = chan_r;

    // Bus write channel holding registers
    logic             aw_hold_r, w_hold_r, bvalid_r;
    logic [7:0]       aw_addr_r;
    logic [31:0]      w_data_r;
    logic [3:0]       w_strb_r;
    logic [1:0]       bresp_r;
    wire              wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    wire [7:0]        wr_word = aw_addr_r & ADDR_WORD;
    wire              wr_cfg  = wr_fire && (wr_word == OFF_CONFIG);
    wire              wr_wthr = wr_fire && (wr_word == OFF_WARN_THR);
    wire              wr_sthr = wr_fire && (wr_word == OFF_SD_THR);
    wire              wr_sts  = wr_fire && (wr_word == OFF_STATUS);
    wire              wr_map  = (wr_word <= OFF_TEMP56);

    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready  = !w_hold_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            bresp_r   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Configuration and threshold registers, byte lanes honoured
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cluster_r  <= CLUSTER_RST;
            adc_en_r   <= ADC_EN_RST;
            warn_thr_r <= WARN_THR_RST;
            sd_thr_r   <= SD_THR_RST;
        end else begin
            if (wr_cfg && w_strb_r[0]) begin
                cluster_r <= w_data_r[CFG_CLUSTER_BIT];
                adc_en_r  <= w_data_r[CFG_ADC_EN_BIT];
            end
            if (wr_wthr && w_strb_r[0]) warn_thr_r[7:0] <= w_data_r[7:0];
            if (wr_wthr && w_strb_r[1]) warn_thr_r[9:8] <= w_data_r[9:8];
            if (wr_sthr && w_strb_r[0]) sd_thr_r[7:0]   <= w_data_r[7:0];
            if (wr_sthr && w_strb_r[1]) sd_thr_r[9:8]   <= w_data_r[9:8];
        end
    end

    // Write-one-to-clear masks
    wire [N_GRP-1:0] clr_warn   = (wr_sts && w_strb_r[0]) ? w_data_r[STS_WARN_LSB +: N_GRP] : '0; // (R15)
    wire [N_GRP-1:0] clr_sd     = (wr_sts && w_strb_r[1]) ? w_data_r[STS_SD_LSB +: N_GRP] : '0;   // (R15)
    wire             clr_second = wr_sts && w_strb_r[2] && w_data_r[STS_SECOND_SHUTDOWN_LEVEL_BIT];

    // Per-group over detection and filter counters
    logic [N_GRP-1:0] warn_set, sd_set;
    for (genvar g = 0; g < N_GRP; g++) begin : g_grp
        logic              w_over, s_over;
        logic [FILT_W-1:0] wcnt_r, scnt_r;
        if (g < N_DIG) begin : g_dig
            logic dw_r, ds_r;
            wire  here = sar_done && (chan_r == CH_GRP0 + CH_W'(g));
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    dw_r <= 1'b0;
                    ds_r <= 1'b0;
                end else if (here) begin
                    dw_r <= (sar_result <= warn_thr_r); // (R12) (R17)
                    ds_r <= (sar_result <= sd_thr_r);   // (R12) (R17)
                end
            end
            assign w_over = dw_r;
            assign s_over = ds_r;
        end else begin : g_ana
            assign w_over = warn_s[g - N_DIG]; // (R12)
            assign s_over = sd_s[g - N_DIG];   // (R12)
        end
        wire s_run = s_over && warn_r[g]; // (R5)
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                wcnt_r <= '0;
                scnt_r <= '0;
            end else begin
                if (!w_over || clr_warn[g]) wcnt_r <= '0;              // (R1)
                else if (wcnt_r != FILT_FULL) wcnt_r <= wcnt_r + 1'b1;
                if (!s_run || clr_sd[g]) scnt_r <= '0;                 // (R2)
                else if (scnt_r != FILT_FULL) scnt_r <= scnt_r + 1'b1;
            end
        end
        assign warn_set[g] = w_over && (wcnt_r == FILT_LAST); // (R1) (R6)
        assign sd_set[g]   = s_run && (scnt_r == FILT_LAST);  // (R2) (R6)
    end

    // Second shutdown level filter
    logic [FILT_W-1:0] cnt2_r;
    wire               run2 = second_s && (|sd_r);
    wire               set2 = run2 && (cnt2_r == FILT_LAST);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt2_r <= '0;
        end else if (!run2 || clr_second) begin
            cnt2_r <= '0;
        end else if (cnt2_r != FILT_FULL) begin
            cnt2_r <= cnt2_r + 1'b1;
        end
    end

    // Sticky flags, a set in the clearing cycle wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            warn_r   <= '0;
            sd_r     <= '0;
            second_r <= 1'b0;
        end else begin
            warn_r   <= warn_set | (warn_r & ~clr_warn); // (R1) (R4)
            sd_r     <= sd_set | (sd_r & ~clr_sd);       // (R2) (R4)
            second_r <= set2 | (second_r & ~clr_second);
        end
    end

    // Output stage switch-off decision
    wire             any_sd   = |sd_r;
    wire             hard_sd  = sd_r[4] | sd_r[5];                            // (R11)
    wire [N_GRP-1:0] off_nxt  = cluster_r ? (sd_r | {N_GRP{hard_sd}})        // (R10) (R11)
                                          : {N_GRP{any_sd}};                  // (R9) (R2)
    logic [N_GRP-1:0] off_r;
    logic             rlow_r, mreg_off_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            off_r      <= '0;
            rlow_r     <= 1'b0;
            mreg_off_r <= 1'b0;
        end else begin
            off_r      <= off_nxt;       // (R4)
            rlow_r     <= |off_nxt;      // (R3)
            mreg_off_r <= second_r;      // (R9) (R11)
        end
    end
    assign group_off          = off_r;
    assign gate_resistive_low = rlow_r;
    assign main_regulator_off = mreg_off_r;

    // Read data words
    wire [31:0] cfg_word  = {30'h0, adc_en_r, cluster_r};
    wire [31:0] sts_word  = {13'h0, second_r, any_sd, |warn_r, 2'h0, sd_r, 2'h0, warn_r}; // (R7)
    wire [31:0] t12_word  = {6'h0, res_r[4], 6'h0, res_r[3]}; // (R7) (R8)
    wire [31:0] t34_word  = {6'h0, res_r[6], 6'h0, res_r[5]}; // (R7) (R8)
    wire [31:0] t56_word  = {6'h0, res_r[8], 6'h0, res_r[7]}; // (R7) (R8)
    wire [7:0]  rd_word   = s_axi_araddr & ADDR_WORD;
    wire        rd_map    = (rd_word <= OFF_TEMP56);
    wire [31:0] rd_mux    = (rd_word == OFF_CONFIG)   ? cfg_word :
                            (rd_word == OFF_WARN_THR) ? {22'h0, warn_thr_r} :
                            (rd_word == OFF_SD_THR)   ? {22'h0, sd_thr_r} :
                            (rd_word == OFF_STATUS)   ? sts_word :
                            (rd_word == OFF_REGULATED_SUPPLY_SENSE)    ? {22'h0, res_r[CH_REGULATED_SUPPLY_SENSE]} :
                            (rd_word == OFF_VS)       ? {22'h0, res_r[CH_VS]} :
                            (rd_word == OFF_WAKE)     ? {22'h0, res_r[CH_WAKE]} :
                            (rd_word == OFF_TEMP12)   ? t12_word :
                            (rd_word == OFF_TEMP34)   ? t34_word :
                            (rd_word == OFF_TEMP56)   ? t56_word : 32'h0;

    // Bus read channel
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule : tcs_thermal

/* dv/tcs_thermal_properties.sv */
`timescale 1ns/1ps
module tcs_thermal_checker import tcs_pkg::*; (
    // Clock and reset
    input wire logic             clk,
    input wire logic             resetn,
    // Read handshake
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic [31:0]      s_axi_rdata,
    // Converter and output stages
    input wire logic [CH_W-1:0]  adc_chan_sel,
    input wire logic [N_GRP-1:0] group_off,
    input wire logic             gate_resistive_low,
    input wire logic             main_regulator_off
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // Cycles with all stages on, saturating
    logic [11:0] since_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            since_r <= 12'h000;
        end else if (|group_off) begin
            since_r <= 12'h000;
        end else if (since_r != 12'hfff) begin
            since_r <= since_r + 12'h001;
        end
    end

    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data left before taken");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while busy");
    a_chan_order: assert property ($changed(adc_chan_sel) |-> adc_chan_sel ==
        (($past(adc_chan_sel) == CH_LAST) ? CH_REGULATED_SUPPLY_SENSE : $past(adc_chan_sel) + 4'h1))
        else $error("converter channel out of order");
    a_chan_dwell: assert property ($changed(adc_chan_sel) |=> $stable(adc_chan_sel) [*8])
        else $error("channel left mid conversion");
    a_gate_follows: assert property (|group_off |-> ##[0:1] gate_resistive_low)
        else $error("gate not resistive low");
    a_regoff_late: assert property ($rose(main_regulator_off) |-> |group_off)
        else $error("regulator off before stages");
    a_two_filters: assert property ($rose(|group_off) |-> since_r >= 12'(2 * FILT_CNT))
        else $error("off before two filter times");

    cover property ($rose(&group_off));
    cover property ($rose(main_regulator_off));
    cover property (s_axi_rvalid && s_axi_rready);
endmodule : tcs_thermal_checker

/* dv/tcs_afe_model.sv */
`timescale 1ns/1ps
module tcs_afe_model import tcs_pkg::*; (
    // Mux select and trial code
    input  wire logic [CH_W-1:0]            chan_sel,
    input  wire logic [ADC_W-1:0]           dac_code,
    // Analog levels given as ideal codes
    input  wire logic [N_CH-1:0][ADC_W-1:0] level,
    // Comparator out
    output logic                            cmp_hi
);
    // An equal trial reads high
    assign cmp_hi = (chan_sel < 4'(N_CH)) ? (level[chan_sel] >= dac_code) : 1'b0;
endmodule : tcs_afe_model

/* dv/tcs_thermal_tb_top.sv */
`timescale 1ns/1ps
module tcs_thermal_tb_top import tcs_pkg::*; ;
    logic                       clk = 1'b0, resetn = 1'b0;
    logic [7:0]                 awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]                wdata = 32'h0, rdata;
    logic                       awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic                       awready, wready, bvalid, arready, rvalid, cmp_hi, gate_rl, reg_off;
    logic [1:0]                 bresp, rresp, ana_warn = 2'b00, ana_sd = 2'b00;
    logic                       ana_second = 1'b0;
    logic [CH_W-1:0]            chan_sel;
    logic [ADC_W-1:0]           dac;
    logic [N_GRP-1:0]           group_off;
    logic [N_CH-1:0][ADC_W-1:0] level;
    int                         err_count = 0, samples_checked = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    tcs_thermal u_dut (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .adc_cmp_hi(cmp_hi), .adc_chan_sel(chan_sel), .adc_sample(), .adc_dac_code(dac),
        .ana_warn_cmp(ana_warn), .ana_sd_cmp(ana_sd), .ana_second_cmp(ana_second),
        .group_off(group_off), .gate_resistive_low(gate_rl), .main_regulator_off(reg_off));

    tcs_afe_model u_afe (.chan_sel(chan_sel), .dac_code(dac), .level(level), .cmp_hi(cmp_hi));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Address and data offered together
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic s_aw, s_w, s_b;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(negedge clk);
            s_aw = awready;
            s_w = wready;
            s_b = bvalid;
            @(posedge clk);
            if (s_aw) awvalid <= 1'b0;
            if (s_w) wvalid <= 1'b0;
        end while (!s_b);
    endtask : axi_write

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RESP_OKAY);
        logic s_a, s_r;
        logic [31:0] d;
        logic [1:0]  r;
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge clk);
            s_a = arready;
            s_r = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (s_a) arvalid <= 1'b0;
        end while (!s_r);
        check("rdata", ed, d);
        check("rresp", 32'(er), 32'(r));
    endtask : rd_chk

    // Output stages sampled mid-cycle
    task automatic outs_chk(input logic [5:0] g, input logic gl, input logic ro);
        @(negedge clk);
        check("group_off", 32'(g), 32'(group_off));
        check("gate_rl", 32'(gl), 32'(gate_rl));
        check("reg_off", 32'(ro), 32'(reg_off));
        @(posedge clk);
    endtask : outs_chk

    task automatic t_reset_map();
        rd_chk(OFF_CONFIG, {30'h0, ADC_EN_RST, CLUSTER_RST});
        rd_chk(OFF_WARN_THR, 32'(WARN_THR_RST));
        rd_chk(OFF_SD_THR, 32'(SD_THR_RST));
        rd_chk(OFF_STATUS, 32'h0);
        rd_chk(8'h28, 32'h0, RESP_SLVERR);
    endtask : t_reset_map

    task automatic t_adc_read();
        repeat (1000) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            rd_chk(OFF_REGULATED_SUPPLY_SENSE + 8'(4 * i), 32'(level[i]));
            rd_chk(OFF_TEMP12 + 8'(4 * i), {6'h0, level[4+2*i], 6'h0, level[3+2*i]});
        end
    endtask : t_adc_read

    task automatic t_warn();
        level[3] <= WARN_THR_RST;
        level[4] <= WARN_THR_RST + 10'h1;
        repeat (900) @(posedge clk);
        rd_chk(OFF_STATUS, 32'h0);
        repeat (1500) @(posedge clk);
        rd_chk(OFF_STATUS, 32'h10001);
        axi_write(OFF_STATUS, 32'h1);
        rd_chk(OFF_STATUS, 32'h0);
        level[3] <= 10'h29d;
        level[4] <= 10'h29e;
        repeat (500) @(posedge clk);
        axi_write(OFF_STATUS, 32'h1);
        outs_chk(6'h00, 1'b0, 1'b0);
    endtask : t_warn

    task automatic t_shutdown();
        level[3] <= SD_THR_RST;
        repeat (1900) @(posedge clk);
        outs_chk(6'h00, 1'b0, 1'b0);
        repeat (1600) @(posedge clk);
        outs_chk(6'h3f, 1'b1, 1'b0);
        rd_chk(OFF_STATUS, 32'h30101);
        axi_write(OFF_STATUS, 32'h101);
        repeat (3) @(posedge clk);
        outs_chk(6'h00, 1'b0, 1'b0);
        repeat (1900) @(posedge clk);
        outs_chk(6'h00, 1'b0, 1'b0);
        repeat (1700) @(posedge clk);
        outs_chk(6'h3f, 1'b1, 1'b0);
        level[3] <= 10'h29d;
        repeat (500) @(posedge clk);
        axi_write(OFF_STATUS, 32'h101);
    endtask : t_shutdown

    task automatic t_cluster();
        axi_write(OFF_CONFIG, 32'h3);
        level[4] <= 10'h100;
        repeat (3500) @(posedge clk);
        outs_chk(6'h02, 1'b1, 1'b0);
        ana_warn <= 2'b01;
        ana_sd   <= 2'b01;
        repeat (2200) @(posedge clk);
        outs_chk(6'h3f, 1'b1, 1'b0);
        ana_second <= 1'b1;
        repeat (1100) @(posedge clk);
        outs_chk(6'h3f, 1'b1, 1'b1);
    endtask : t_cluster

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        for (int i = 0; i < N_CH; i++) begin
            level[i] = 10'h29a + 10'(i);
        end
        level[1] = 10'h001;
        level[2] = 10'h3ff;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset_map();
        t_adc_read();
        t_warn();
        t_shutdown();
        t_cluster();
        finish_test();
    end

    // Watchdog
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule : tcs_thermal_tb_top

bind tcs_thermal tcs_thermal_checker u_chk (.clk(clk), .resetn(resetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .adc_chan_sel(adc_chan_sel),
    .group_off(group_off), .gate_resistive_low(gate_resistive_low),
    .main_regulator_off(main_regulator_off));
